// ### logic/timing_meas_range_autorange_ctrl.sv
// top: wishbone command port over three timing-function range controllers
`timescale 1ns/1ns
// Summary of operation
// - frequency autorange set accepts 0/1/OFF/ON and switches auto ranging
// - autorange query answers 0 for off, 1 for on
// - pulse width keeps its own settable, queryable autorange flag
// - duty cycle keeps its own settable, queryable autorange flag
// - factory reset turns every autorange flag on
// - with autorange on, step down when input under ten percent of range
// - selecting a discrete range clears that function's autorange flag
// - pulse width accepts 100 mV..750 V, MIN, MAX, DEF selects auto
// - duty cycle accepts the same ranges and keywords
// - manual-range overload reports positive or negative overload sentinel
// - query during an auto range change returns the changing sentinel
// - factory reset sets pulse width and duty cycle to 100 mV, auto on
// - range query returns selected range, or MIN/MAX allowed range
module timing_meas_range_autorange_ctrl
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RESETN,
   // wishbone slave
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic     [31:0]  O_WB_DAT,
   output logic             O_WB_ACK,
   // measured input per function, millivolts, with sign
   input  wire logic [19:0] I_FREQ_MEAS,
   input  wire logic [19:0] I_PWID_MEAS,
   input  wire logic [19:0] I_DCYC_MEAS,
   input  wire logic        I_MEAS_VALID,
   input  wire logic        I_MEAS_NEG,
   input  wire logic        I_MEAS_OVER,
   // selected ranges to the front end
   output logic     [2:0]   O_FREQ_RANGE,
   output logic     [2:0]   O_PWID_RANGE,
   output logic     [2:0]   O_DCYC_RANGE,
   output logic             O_OVERLOAD_FRONT_PANEL_MARKER,
   output logic             O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER
);
   logic        req;
   logic        wr_cmd;
   logic [3:0]  op;
   logic [1:0]  func;
   logic [3:0]  arg;
   logic [1:0]  qmod;
   logic [31:0] answer;
   logic [2:0]  auto_on;
   logic [2:0]  range_q [3];
   logic [2:0]  changing;
   logic [2:0]  set_auto;
   logic [2:0]  set_range;
   logic        fact_reset;
   logic [19:0] meas [3];
   logic        ovl;

   assign req    = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   // a write lands on the edge where the master sees ack; the low byte lane carries the opcode
   assign wr_cmd = I_WB_CYC && I_WB_STB && O_WB_ACK && I_WB_WE && (I_WB_ADR == ADDR_CMD) && I_WB_SEL[0];
   // parser upstream folds prefix and long/short keywords into one opcode
   assign op     = I_WB_DAT[CMD_OP_LSB +: 4];
   assign func   = I_WB_DAT[CMD_FUNC_LSB +: 2];
   assign arg    = I_WB_DAT[CMD_ARG_LSB +: 4];
   assign qmod   = I_WB_DAT[CMD_QMOD_LSB +: 2];
   assign fact_reset = wr_cmd && (op == OP_FACT_RESET);
   assign meas[0] = I_FREQ_MEAS;
   assign meas[1] = I_PWID_MEAS;
   assign meas[2] = I_DCYC_MEAS;
   assign ovl = I_MEAS_VALID && I_MEAS_OVER;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_func
         // any value but 0 counts as ON, so 1 and ON are one code
         assign set_auto[g]  = wr_cmd && (op == OP_SET_AUTO) && (func == 2'(g));
         // unknown range codes are ignored but still answered
         assign set_range[g] = wr_cmd && (op == OP_SET_RANGE) && (func == 2'(g)) &&
                               ((arg <= ARG_750V) || (arg == ARG_MIN) ||
                                (arg == ARG_MAX) || (arg == ARG_DEF));
         tmr_func_range u_rng (
            .clk        (I_SYS_CLK),
            .rst_n      (I_RESETN),
            .set_auto   (set_auto[g]),
            .auto_val   (arg != 4'h0),
            .set_range  (set_range[g]),
            .range_arg  (arg),
            .fact_reset (fact_reset),
            .meas_mv    (meas[g]),
            .meas_valid (I_MEAS_VALID),
            .auto_on    (auto_on[g]),
            .range      (range_q[g]),
            .changing   (changing[g])
         );
      end
   endgenerate

   // query answer latched at the write of a query command
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         answer <= 32'h00000000;
      end else if (wr_cmd && func <= FUNC_DCYC) begin
         case (op)
            OP_QRY_AUTO: answer <= {31'h0, auto_on[func]};
            OP_QRY_RANGE: begin
               case (qmod)
                  QMOD_MIN: answer <= {29'h0, RANGE_MIN};
                  QMOD_MAX: answer <= {29'h0, RANGE_MAX};
                  default:  answer <= {29'h0, range_q[func]};
               endcase
            end
            OP_QRY_READ: begin
               if (changing[func]) begin
                  answer <= {29'h0, ANS_CHANGING} << 29;
               end else if (ovl && !auto_on[func]) begin
                  answer <= {29'h0, (I_MEAS_NEG ? ANS_NEG_OL : ANS_POS_OL)} << 29;
               end else begin
                  answer <= {12'h0, meas[func]};
               end
            end
            default: answer <= answer;
         endcase
      end
   end

   // front panel overload markers on manual frequency ranging
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         O_OVERLOAD_FRONT_PANEL_MARKER          <= 1'b0;
         O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER <= 1'b0;
      end else begin
         O_OVERLOAD_FRONT_PANEL_MARKER          <= ovl && !auto_on[0] && !I_MEAS_NEG;
         O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER <= ovl && !auto_on[0] && I_MEAS_NEG;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         O_FREQ_RANGE <= RANGE_RESET;
         O_PWID_RANGE <= RANGE_RESET;
         O_DCYC_RANGE <= RANGE_RESET;
      end else begin
         O_FREQ_RANGE <= range_q[0];
         O_PWID_RANGE <= range_q[1];
         O_DCYC_RANGE <= range_q[2];
      end
   end

   // single-cycle wishbone answer, unmapped reads return zero
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_RESETN) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= req;
         if (req && !I_WB_WE) begin
            case (I_WB_ADR)
               ADDR_FREQ_CFG: O_WB_DAT <= {28'h0, range_q[0], auto_on[0]};
               ADDR_PWID_CFG: O_WB_DAT <= {28'h0, range_q[1], auto_on[1]};
               ADDR_DCYC_CFG: O_WB_DAT <= {28'h0, range_q[2], auto_on[2]};
               ADDR_QUERY:    O_WB_DAT <= answer;
               ADDR_STATUS:   O_WB_DAT <= {29'h0, changing};
               default:       O_WB_DAT <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // timing_meas_range_autorange_ctrl

// ### logic/tmr_pkg.sv
// package: register map, range codes and constants for the timing range controller
package tmr_pkg;
   localparam logic [7:0] ADDR_CMD          = 8'h00;
   localparam logic [7:0] ADDR_FREQ_CFG     = 8'h04;
   localparam logic [7:0] ADDR_PWID_CFG     = 8'h08;
   localparam logic [7:0] ADDR_DCYC_CFG     = 8'h0c;
   localparam logic [7:0] ADDR_QUERY        = 8'h10;
   localparam logic [7:0] ADDR_STATUS       = 8'h14;

   // command register fields
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_FUNC_LSB = 4;
   localparam int CMD_ARG_LSB  = 8;
   localparam int CMD_QMOD_LSB = 12;

   // functions
   localparam logic [1:0] FUNC_FREQ = 2'h0;
   localparam logic [1:0] FUNC_PWID = 2'h1;
   localparam logic [1:0] FUNC_DCYC = 2'h2;

   // opcodes
   localparam logic [3:0] OP_SET_AUTO   = 4'h1;
   localparam logic [3:0] OP_QRY_AUTO   = 4'h2;
   localparam logic [3:0] OP_SET_RANGE  = 4'h3;
   localparam logic [3:0] OP_QRY_RANGE  = 4'h4;
   localparam logic [3:0] OP_QRY_READ   = 4'h5;
   localparam logic [3:0] OP_FACT_RESET = 4'h6;

   // range argument codes
   localparam logic [3:0] ARG_100MV = 4'h0;
   localparam logic [3:0] ARG_1V    = 4'h1;
   localparam logic [3:0] ARG_10V   = 4'h2;
   localparam logic [3:0] ARG_100V  = 4'h3;
   localparam logic [3:0] ARG_750V  = 4'h4;
   localparam logic [3:0] ARG_MIN   = 4'h8;
   localparam logic [3:0] ARG_MAX   = 4'h9;
   localparam logic [3:0] ARG_DEF   = 4'ha;

   // query modifiers
   localparam logic [1:0] QMOD_NONE = 2'h0;
   localparam logic [1:0] QMOD_MIN  = 2'h1;
   localparam logic [1:0] QMOD_MAX  = 2'h2;

   localparam logic [2:0] RANGE_MIN   = 3'h0;
   localparam logic [2:0] RANGE_MAX   = 3'h4;
   localparam logic [2:0] RANGE_RESET = 3'h0;
   localparam logic       AUTO_RESET  = 1'b1;

   // full scale of each range in millivolts
   localparam logic [19:0] FS_100MV = 20'h00064;
   localparam logic [19:0] FS_1V    = 20'h003e8;
   localparam logic [19:0] FS_10V   = 20'h02710;
   localparam logic [19:0] FS_100V  = 20'h186a0;
   localparam logic [19:0] FS_750V  = 20'hb71b0;

   // answer codes on the query register
   localparam logic [2:0] ANS_VALUE   = 3'h0;
   localparam logic [2:0] ANS_POS_OL  = 3'h1;
   localparam logic [2:0] ANS_NEG_OL  = 3'h2;
   localparam logic [2:0] ANS_CHANGING = 3'h3;

   // settle time of a range switch
   localparam int SETTLE_NS     = 1000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DOWN_PCT      = 10;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SETTLE = 2'b01
   } rng_state_e;
endpackage

// ### logic/tmr_func_range.sv
// one function's autorange flag, range selection and autorange stepping
`timescale 1ns/1ns
module tmr_func_range
   import tmr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   // commands for this function
   input  wire logic        set_auto,
   input  wire logic        auto_val,
   input  wire logic        set_range,
   input  wire logic [3:0]  range_arg,
   input  wire logic        fact_reset,
   // measured magnitude in millivolts
   input  wire logic [19:0] meas_mv,
   input  wire logic        meas_valid,
   // state
   output logic             auto_on,
   output logic [2:0]       range,
   output logic             changing
);
   rng_state_e   state;
   logic [15:0]  settle_cnt;
   logic [19:0]  full_scale;

   always_comb begin
      case (range)
         3'h0:    full_scale = FS_100MV;
         3'h1:    full_scale = FS_1V;
         3'h2:    full_scale = FS_10V;
         3'h3:    full_scale = FS_100V;
         default: full_scale = FS_750V;
      endcase
   end

   // below ten percent: meas*100 < fs*10
   wire logic [26:0] meas_x100 = 27'(meas_mv) * 27'd100;
   wire logic [26:0] fs_x10    = 27'(full_scale) * 27'(DOWN_PCT);
   wire logic        go_down   = auto_on && meas_valid && (state == ST_IDLE) &&
                                 (range != RANGE_MIN) && (meas_x100 < fs_x10);

   always_ff @(posedge clk) begin
      if (!rst_n || fact_reset) begin
         auto_on <= AUTO_RESET;
      end else if (set_range) begin
         auto_on <= (range_arg == ARG_DEF);
      end else if (set_auto) begin
         auto_on <= auto_val;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || fact_reset) begin
         range <= RANGE_RESET;
      end else if (set_range) begin
         case (range_arg)
            ARG_100MV, ARG_1V, ARG_10V, ARG_100V, ARG_750V: range <= range_arg[2:0];
            ARG_MIN: range <= RANGE_MIN;
            ARG_MAX: range <= RANGE_MAX;
            default: range <= range;
         endcase
      end else if (go_down) begin
         range <= range - 3'h1;
      end
   end

   // a range step holds the query answer at the changing sentinel until settled
   always_ff @(posedge clk) begin
      if (!rst_n || fact_reset || set_range || (set_auto && !auto_val)) begin
         state      <= ST_IDLE;
         settle_cnt <= '0;
         changing   <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (go_down) begin
                  state      <= ST_SETTLE;
                  settle_cnt <= 16'(SETTLE_CYCLES - 1);
                  changing   <= 1'b1;
               end
            end
            ST_SETTLE: begin
               if (settle_cnt == 16'h0000) begin
                  state    <= ST_IDLE;
                  changing <= 1'b0;
               end else begin
                  settle_cnt <= settle_cnt - 16'h0001;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // tmr_func_range

// ### tb/tmr_props.sv
// checker: bus handshake and range outputs of the range controller
`timescale 1ns/1ns
module tmr_props
   import tmr_pkg::*;
(
   // clock, reset and bus
   input wire logic        I_SYS_CLK,
   input wire logic        I_RESETN,
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [7:0]  I_WB_ADR,
   input wire logic [3:0]  I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   input wire logic        O_WB_ACK,
   // front end
   input wire logic [2:0]  O_FREQ_RANGE,
   input wire logic [2:0]  O_PWID_RANGE,
   input wire logic [2:0]  O_DCYC_RANGE,
   input wire logic        O_OVERLOAD_FRONT_PANEL_MARKER,
   input wire logic        O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);
   logic cmd;
   logic fact;
   assign cmd  = I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_ADR == ADDR_CMD && I_WB_SEL[0];
   assign fact = cmd && I_WB_DAT[3:0] == OP_FACT_RESET;
   // range output lags the command by two edges
   property p_rng(logic [1:0] f, logic [2:0] r);
      cmd && I_WB_DAT[3:0] == OP_SET_RANGE && I_WB_DAT[5:4] == f && I_WB_DAT[11:8] <= 4'h4
         |=> ##1 r == $past(I_WB_DAT[10:8], 2);
   endproperty
   a_ack_single_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   a_ack_answer_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("ack not one cycle after request");
   a_freq_range_set: assert property (p_rng(FUNC_FREQ, O_FREQ_RANGE))
      else $error("frequency range not taken");
   a_pwid_range_set: assert property (p_rng(FUNC_PWID, O_PWID_RANGE))
      else $error("pulse width range not taken");
   a_dcyc_range_set: assert property (p_rng(FUNC_DCYC, O_DCYC_RANGE))
      else $error("duty cycle range not taken");
   a_fact_range_low: assert property (fact |=> ##1 O_FREQ_RANGE == RANGE_RESET
      && O_PWID_RANGE == RANGE_RESET && O_DCYC_RANGE == RANGE_RESET)
      else $error("factory reset left a range up");
   // auto is on after factory reset, so no overload may show
   a_fact_marker_off: assert property (fact |=> ##2 !O_OVERLOAD_FRONT_PANEL_MARKER
      && !O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER)
      else $error("overload shown under autorange");
   a_step_one_range: assert property (O_FREQ_RANGE < $past(O_FREQ_RANGE) && !$past(cmd, 2)
      |-> O_FREQ_RANGE == $past(O_FREQ_RANGE) - 3'h1)
      else $error("autorange skipped a range");
   c_range_cmd: cover property (cmd && I_WB_DAT[3:0] == OP_SET_RANGE);
   c_step_down: cover property (O_FREQ_RANGE < $past(O_FREQ_RANGE));
   c_pos_ol: cover property (O_OVERLOAD_FRONT_PANEL_MARKER);
   c_neg_ol: cover property (O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER);
endmodule // tmr_props

// ### tb/tmr_host.sv
// host model: wishbone master that sends commands and repeats queries
`timescale 1ns/1ns
module tmr_host
   import tmr_pkg::*;
(
   // bus
   input  wire logic        i_clk,
   input  wire logic        i_ack,
   input  wire logic [31:0] i_dat,
   output logic             o_cyc,
   output logic             o_stb,
   output logic             o_we,
   output logic [7:0]       o_adr,
   output logic [3:0]       o_sel,
   output logic [31:0]      o_dat
);
   initial begin
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge i_clk);
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, 4'hf, d};
      do @(posedge i_clk); while (i_ack !== 1'b1);
      q = i_dat;
      // released address and data lines show the inverse so stale values cannot pass; cyc, stb and we go low
      {o_cyc, o_stb, o_we, o_adr, o_dat} <= {3'h0, ~a, ~d};
   endtask
   // readings only; range queries are left out while autoranging
   task automatic query(input logic [15:0] c, output logic [31:0] q);
      logic [31:0] u;
      xfer(1'b1, ADDR_CMD, {16'h0, c}, u);
      xfer(1'b0, ADDR_QUERY, 32'h0, q);
      for (int n = 0; n < 40 && q[31:29] == ANS_CHANGING; n++) begin
         repeat (20) @(posedge i_clk);
         xfer(1'b1, ADDR_CMD, {16'h0, c}, u);
         xfer(1'b0, ADDR_QUERY, 32'h0, q);
      end
   endtask
endmodule // tmr_host

// ### tb/tb_top.sv
// testbench: command rows, then autorange, sentinel and overload cases
`timescale 1ns/1ns
module tb_top;
   import tmr_pkg::*;
   logic        clk, rst_n, cyc, stb, we, ack, vld, neg, over, pos_ol, neg_ol;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [19:0] fmeas, pmeas, dmeas;
   logic [2:0]  frng, prng, drng;
   int          err_total, checked;
   // {command, read address, expected}
   logic [31:0] rows [20] = '{32'h00000401, 32'h00000801, 32'h00000c01, 32'h00001800,
      32'h00010400, 32'h01010401, 32'h00021001, 32'h02130804, 32'h0a130805, 32'h00110804,
      32'h00121000, 32'h09230c08, 32'h00241004, 32'h10241000, 32'h08230c00, 32'h20241004,
      32'h01210c01, 32'h00060801, 32'h00000c01, 32'h00000401};
   timing_meas_range_autorange_ctrl i_timing_meas_range_autorange_ctrl (
      .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_FREQ_MEAS(fmeas), .I_PWID_MEAS(pmeas), .I_DCYC_MEAS(dmeas), .I_MEAS_VALID(vld),
      .I_MEAS_NEG(neg), .I_MEAS_OVER(over), .O_FREQ_RANGE(frng), .O_PWID_RANGE(prng),
      .O_DCYC_RANGE(drng), .O_OVERLOAD_FRONT_PANEL_MARKER(pos_ol),
      .O_NEGATIVE_OVERLOAD_FRONT_PANEL_MARKER(neg_ol));
   tmr_host i_tmr_host (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
      .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #(20000 * 8);
      err_total++;
      stop_test();
   end
   initial begin
      {rst_n, neg, over} = 3'h0;
      vld = 1'b1;
      // 5 V keeps the 100 mV to 10 V ranges above their step-down point
      {fmeas, pmeas, dmeas} = {3{20'h01388}};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         i_tmr_host.xfer(1'b1, ADDR_CMD, {16'h0, rows[i][31:16]}, q);
         i_tmr_host.xfer(1'b0, rows[i][15:8], 32'h0, q);
         chk($sformatf("row %0d", i), {24'h0, rows[i][7:0]}, q);
      end
      i_tmr_host.xfer(1'b1, ADDR_CMD, 32'h0403, q);
      i_tmr_host.xfer(1'b1, ADDR_CMD, 32'h0101, q);
      fmeas <= 20'h00032;
      for (int n = 0; n < 300 && frng !== 3'h3; n++) @(posedge clk);
      chk("step", 32'h3, {29'h0, frng});
      i_tmr_host.xfer(1'b0, ADDR_STATUS, 32'h0, q);
      chk("status", 32'h1, q);
      i_tmr_host.xfer(1'b1, ADDR_CMD, 32'h0005, q);
      i_tmr_host.xfer(1'b0, ADDR_QUERY, 32'h0, q);
      chk("changing", {29'h0, ANS_CHANGING}, {29'h0, q[31:29]});
      i_tmr_host.query(16'h0005, q);
      chk("reading", 32'h32, q);
      for (int n = 0; n < 700 && frng !== 3'h0; n++) @(posedge clk);
      i_tmr_host.xfer(1'b0, ADDR_FREQ_CFG, 32'h0, q);
      chk("lowest", 32'h1, q);
      // manual range, as a host is advised to use
      i_tmr_host.xfer(1'b1, ADDR_CMD, 32'h0003, q);
      over <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         neg <= k[0];
         for (int n = 0; n < 50 && (k ? neg_ol : pos_ol) !== 1'b1; n++) @(posedge clk);
         chk("marker", 32'h1, {31'h0, k ? neg_ol : pos_ol});
         chk("other marker", 32'h0, {31'h0, k ? pos_ol : neg_ol});
         i_tmr_host.xfer(1'b1, ADDR_CMD, 32'h0005, q);
         i_tmr_host.xfer(1'b0, ADDR_QUERY, 32'h0, q);
         chk("overload", k + 1, {29'h0, q[31:29]});
      end
      // without a valid measurement no overload may show
      vld <= 1'b0;
      repeat (3) @(posedge clk);
      chk("marker idle", 32'h0, {30'h0, pos_ol, neg_ol});
      // reset in mid-run brings back the power-up settings
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      i_tmr_host.xfer(1'b0, ADDR_FREQ_CFG, 32'h0, q);
      chk("reset cfg", 32'h1, q);
      stop_test();
   end
endmodule // tb_top
bind timing_meas_range_autorange_ctrl tmr_props i_tmr_props (.*);
